// [pscl_host_model.sv]
// host model driving the serial configuration pins
`timescale 1ns/1ps
module pscl_host_model (
  input wire logic pclk,
  output logic     ser_clk_in,
  output logic     ser_data_in,
  output logic     ser_load_in
);
  initial begin
    ser_clk_in  = 1'b0;
    ser_data_in = 1'b0;
    ser_load_in = 1'b0;
  end
  // one frame msb first; slow stretches each clock phase
  task automatic send(input logic [13:0] word, input int slow);
    for (int i = 13; i >= 0; i--) begin
      @(posedge pclk);
      ser_clk_in  <= 1'b0;
      ser_data_in <= word[i];
      repeat (slow) @(posedge pclk);
      ser_clk_in <= 1'b1;
      repeat (slow) @(posedge pclk);
    end
    @(posedge pclk);
    ser_clk_in  <= 1'b0; // clock rests low between frames
    ser_data_in <= 1'b0; // released line falls to its pulldown
    ser_load_in <= 1'b1;
    repeat (2) @(posedge pclk);
    ser_load_in <= 1'b0;
  endtask : send
endmodule : pscl_host_model

// [pscl_monitor.sv]
// port checker for the synthesizer configuration logic
`timescale 1ns/1ps
module pscl_monitor (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic [pscl_pkg::ADDR_W-1:0] paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        out_enable_in,
  input wire logic                        ref_source_select,
  input wire logic                        external_reference_in,
  input wire logic                        crystal_pins,
  input wire logic                        vco_in,
  input wire logic                        ref_clk_out,
  input wire logic                        synth_out,
  input wire logic                        loop_fb_out
);
  logic       vco_q;
  logic [2:0] rise_h;
  logic [3:0] en_h;
  logic [5:0] off_cnt;
  wire        ref_pick = ref_source_select ? crystal_pins : external_reference_in;
  wire        bad_addr = (paddr > 8'h10) || (paddr[1:0] != 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_q   <= 1'b0;
      rise_h  <= 3'h0;
      en_h    <= 4'h0;
      off_cnt <= 6'h00;
    end else begin
      vco_q   <= vco_in;
      rise_h  <= {rise_h[1:0], vco_in & ~vco_q};
      en_h    <= {en_h[2:0], out_enable_in};
      // saturates so a long stop never wraps
      off_cnt <= out_enable_in ? 6'h00 : off_cnt + {5'h00, off_cnt != 6'h3f};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_addr_a: assert property (setup_s ##0 bad_addr |=> pslverr)
    else $error("unmapped access without error");
  ref_path_a: assert property ($past(presetn, 2) |-> ref_clk_out == $past(ref_pick))
    else $error("wrong reference source");
  fb_pulse_a: assert property (loop_fb_out |=> !loop_fb_out)
    else $error("feedback pulse too long");
  rise_on_vco_a: assert property ($rose(synth_out) |-> rise_h != 3'h0)
    else $error("output rose off a vco rise");
  rise_needs_en_a: assert property ($rose(synth_out) |-> en_h != 4'h0)
    else $error("output rose while disabled");
  idle_low_a: assert property (off_cnt > 6'h28 |-> !synth_out)
    else $error("output not resting low");
endmodule : pscl_monitor
bind pscl_top pscl_monitor i_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .out_enable_in(out_enable_in), .ref_source_select(ref_source_select),
  .external_reference_in(external_reference_in), .crystal_pins(crystal_pins),
  .vco_in(vco_in), .ref_clk_out(ref_clk_out), .synth_out(synth_out),
  .loop_fb_out(loop_fb_out));

// [pscl_pkg.sv]
// shared constants and types for the synthesizer configuration logic
package pscl_pkg;

  // widths
  localparam int LOOP_DIV_W = 9;
  localparam int OUT_DIV_W  = 2;
  localparam int DIAG_W     = 3;
  localparam int SHIFT_W    = DIAG_W + OUT_DIV_W + LOOP_DIV_W;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // shift register field positions, first bit shifted in ends at the top
  localparam int SH_LOOP_LSB = 0;
  localparam int SH_OUT_LSB  = LOOP_DIV_W;
  localparam int SH_DIAG_LSB = LOOP_DIV_W + OUT_DIV_W;

  // output divider codes
  localparam logic [1:0] DIV_BY_2 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;
  localparam logic [1:0] DIV_BY_8 = 2'h2;
  localparam logic [1:0] DIV_BY_1 = 2'h3;

  // diagnostic select codes
  localparam logic [2:0] DIAG_REF   = 3'h0;
  localparam logic [2:0] DIAG_VCO   = 3'h1;
  localparam logic [2:0] DIAG_DIV   = 3'h2;
  localparam logic [2:0] DIAG_FB    = 3'h3;
  localparam logic [2:0] DIAG_LOW   = 3'h4;
  localparam logic [2:0] DIAG_HIGH  = 3'h5;
  localparam logic [2:0] DIAG_SHIFT = 3'h6;
  localparam logic [2:0] DIAG_GATE  = 3'h7;

  // reset values follow the undriven pin defaults
  localparam logic [LOOP_DIV_W-1:0] LOOP_DIV_RST = 9'h1ff;
  localparam logic [OUT_DIV_W-1:0]  OUT_DIV_RST  = 2'h3;
  localparam logic [DIAG_W-1:0]     DIAG_RST     = 3'h0;
  localparam logic [SHIFT_W-1:0]    SHIFT_RST    = 14'h0000;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SHIFT  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FBCNT  = 8'h10;

  // control register field
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RST = 1'b0;

  // configuration latch contents
  typedef struct packed {
    logic [DIAG_W-1:0]     diag_sel;
    logic [OUT_DIV_W-1:0]  out_div;
    logic [LOOP_DIV_W-1:0] loop_div;
  } pscl_cfg_t;

  localparam pscl_cfg_t CFG_RST = '{diag_sel: DIAG_RST, out_div: OUT_DIV_RST,
                                     loop_div: LOOP_DIV_RST};

  // status word
  typedef struct packed {
    logic gate_on;
    logic out_enable;
    logic ref_sel;
    logic ser_load;
    logic par_load;
  } pscl_status_t;

endpackage : pscl_pkg

// [pscl_top.sv]
// configuration logic of the programmable clock synthesizer, with an apb view
// Operation
// - output divider code 00 /2, 01 /4, 10 /8, 11 /1 of vco
// - reference select high picks crystal, low picks external reference
// - output enable high lets synthesized output toggle, low stops it
// - enable and disable take effect only at output phase start, no runts
// - serial data sampled into shift register on each serial clock rise
// - latches follow shift register while serial strobe high, hold at fall
// - latches follow parallel inputs while parallel strobe low, hold at rise
// - loop divider is a 9-bit value, bit 8 msb, bit 0 lsb
// - 3-bit diagnostic select, serial only, picks the diagnostic output source
// - serial strobe loads the same latches as the parallel interface
// - undriven pulldown inputs read 0, pullup inputs read 1
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module pscl_top #(
  parameter int LOOP_DIV_W = pscl_pkg::LOOP_DIV_W,
  parameter int FBCNT_W    = 16
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [pscl_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pscl_pkg::DATA_W-1:0]   pwdata,
  output logic      [pscl_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          ser_clk_in,
  input  wire logic                          ser_data_in,
  input  wire logic                          ser_load_in,
  input  wire logic                          par_load_in,
  input  wire logic [LOOP_DIV_W-1:0]         loop_div_in,
  input  wire logic [pscl_pkg::OUT_DIV_W-1:0] out_div_in,
  input  wire logic                          out_enable_in,
  input  wire logic                          ref_source_select,
  input  wire logic                          external_reference_in,
  input  wire logic                          crystal_pins,
  input  wire logic                          vco_in,
  output logic                               ref_clk_out,
  output logic                               synth_out,
  output logic                               diag_out,
  output logic                               loop_fb_out
);

  // the shift layout and the config struct are fixed at the documented width
  if (LOOP_DIV_W != pscl_pkg::LOOP_DIV_W) begin : g_bad_width
    $error("pscl_top: LOOP_DIV_W must equal the configuration latch width");
  end
  if (FBCNT_W < 1 || FBCNT_W > pscl_pkg::DATA_W) begin : g_bad_cnt
    $error("pscl_top: FBCNT_W must lie between 1 and the bus width");
  end

  typedef enum logic [1:0] {
    GATE_OFF = 2'b01,
    GATE_ON  = 2'b10
  } pscl_gate_t;

  // ---------------------------------------------------------------------
  // serial shift interface
  // ---------------------------------------------------------------------
  logic                           ser_clk_prev_reg;
  logic [pscl_pkg::SHIFT_W-1:0]   shift_reg;
  logic [pscl_pkg::SHIFT_W-1:0]   shift_next;
  wire                            ser_clk_rise;

  // pins are synchronous to pclk, so a rise is one pclk wide
  assign ser_clk_rise = ser_clk_in & ~ser_clk_prev_reg;
  assign shift_next   = ser_clk_rise ?
                        {shift_reg[pscl_pkg::SHIFT_W-2:0], ser_data_in} :
                        shift_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_clk_prev_reg <= 1'b0;
      shift_reg        <= pscl_pkg::SHIFT_RST;
    end else begin
      ser_clk_prev_reg <= ser_clk_in;
      shift_reg        <= shift_next;
    end
  end

  // ---------------------------------------------------------------------
  // configuration latches
  // ---------------------------------------------------------------------
  pscl_pkg::pscl_cfg_t cfg_reg;
  pscl_pkg::pscl_cfg_t cfg_next;
  pscl_pkg::pscl_cfg_t cfg_from_serial;
  pscl_pkg::pscl_cfg_t cfg_from_pins;
  wire                 ser_open;
  wire                 par_open;

  // serial decode of the shift register into latch fields
  assign cfg_from_serial.diag_sel =
    shift_reg[pscl_pkg::SH_DIAG_LSB +: pscl_pkg::DIAG_W];
  assign cfg_from_serial.out_div  =
    shift_reg[pscl_pkg::SH_OUT_LSB +: pscl_pkg::OUT_DIV_W];
  assign cfg_from_serial.loop_div =
    shift_reg[pscl_pkg::SH_LOOP_LSB +: LOOP_DIV_W];

  // the parallel port never touches the diagnostic select
  assign cfg_from_pins.diag_sel = cfg_reg.diag_sel;
  assign cfg_from_pins.out_div  = out_div_in;
  assign cfg_from_pins.loop_div = loop_div_in;

  assign ser_open = ser_load_in;
  assign par_open = ~par_load_in;

  // both strobes open at once: serial wins, it is the reprogramming path
  assign cfg_next = ser_open ? cfg_from_serial :
                    par_open ? cfg_from_pins   :
                    cfg_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= pscl_pkg::CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ---------------------------------------------------------------------
  // reference source selection
  // ---------------------------------------------------------------------
  logic ref_clk_reg;
  wire  ref_mux;

  assign ref_mux = ref_source_select ? crystal_pins : external_reference_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_clk_reg <= 1'b0;
    end else begin
      ref_clk_reg <= ref_mux;
    end
  end

  // ---------------------------------------------------------------------
  // output divider and synchronous gate
  // ---------------------------------------------------------------------
  logic       vco_prev_reg;
  logic [1:0] div_cnt_reg;
  logic [1:0] div_cnt_next;
  logic       div_q_reg;
  logic       div_q_next;
  logic [1:0] half_last;
  logic       ctrl_hold_reg;
  pscl_gate_t gate_reg;
  pscl_gate_t gate_next;
  logic       synth_reg;
  wire        vco_rise;
  wire        div_wrap;
  wire        bypass;
  wire        phase_start;
  wire        want_on;
  wire        synth_next;

  assign vco_rise = vco_in & ~vco_prev_reg;
  assign bypass   = (cfg_reg.out_div == pscl_pkg::DIV_BY_1);

  // last count of each half period, in vco rising edges
  always_comb begin
    unique case (cfg_reg.out_div)
      pscl_pkg::DIV_BY_2: half_last = 2'h0;
      pscl_pkg::DIV_BY_4: half_last = 2'h1;
      pscl_pkg::DIV_BY_8: half_last = 2'h3;
      pscl_pkg::DIV_BY_1: half_last = 2'h0;
    endcase
  end

  assign div_wrap     = vco_rise & (div_cnt_reg >= half_last);
  assign div_cnt_next = !vco_rise ? div_cnt_reg :
                        div_wrap  ? 2'h0 : 2'(div_cnt_reg + 2'h1);
  assign div_q_next   = div_wrap ? ~div_q_reg : div_q_reg;

  // a phase starts where the output would go high; changing the gate there
  // means the preceding low half is always complete
  assign phase_start = bypass ? vco_rise : (div_wrap & ~div_q_reg);

  assign want_on = out_enable_in & ~ctrl_hold_reg;

  always_comb begin
    gate_next = gate_reg;
    unique case (gate_reg)
      GATE_OFF: if (phase_start && want_on) begin
        gate_next = GATE_ON;
      end
      GATE_ON: if (phase_start && !want_on) begin
        gate_next = GATE_OFF;
      end
      default: gate_next = GATE_OFF;
    endcase
  end

  // disabled output rests low
  assign synth_next = (gate_next == GATE_ON) &
                      (bypass ? vco_in : div_q_next);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_prev_reg <= 1'b0;
      div_cnt_reg  <= 2'h0;
      div_q_reg    <= 1'b0;
      gate_reg     <= GATE_OFF;
      synth_reg    <= 1'b0;
    end else begin
      vco_prev_reg <= vco_in;
      div_cnt_reg  <= div_cnt_next;
      div_q_reg    <= div_q_next;
      gate_reg     <= gate_next;
      synth_reg    <= synth_next;
    end
  end

  // ---------------------------------------------------------------------
  // loop feedback divider
  // ---------------------------------------------------------------------
  logic [LOOP_DIV_W-1:0] fb_cnt_reg;
  logic [LOOP_DIV_W-1:0] fb_cnt_next;
  logic                  fb_pulse_reg;
  logic [FBCNT_W-1:0]    fb_total_reg;
  wire                   fb_wrap;

  // a zero divider value wraps on every vco rising edge
  assign fb_wrap     = vco_rise & (fb_cnt_reg >= cfg_reg.loop_div);
  assign fb_cnt_next = !vco_rise ? fb_cnt_reg :
                       fb_wrap   ? '0 : LOOP_DIV_W'(fb_cnt_reg + 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt_reg   <= '0;
      fb_pulse_reg <= 1'b0;
      fb_total_reg <= '0;
    end else begin
      fb_cnt_reg   <= fb_cnt_next;
      fb_pulse_reg <= fb_wrap;
      fb_total_reg <= fb_wrap ? FBCNT_W'(fb_total_reg + 1'b1) : fb_total_reg;
    end
  end

  // ---------------------------------------------------------------------
  // diagnostic output
  // ---------------------------------------------------------------------
  logic diag_reg;
  logic diag_next;

  always_comb begin
    unique case (cfg_reg.diag_sel)
      pscl_pkg::DIAG_REF:   diag_next = ref_clk_reg;
      pscl_pkg::DIAG_VCO:   diag_next = vco_prev_reg;
      pscl_pkg::DIAG_DIV:   diag_next = div_q_reg;
      pscl_pkg::DIAG_FB:    diag_next = fb_pulse_reg;
      pscl_pkg::DIAG_LOW:   diag_next = 1'b0;
      pscl_pkg::DIAG_HIGH:  diag_next = 1'b1;
      pscl_pkg::DIAG_SHIFT: diag_next = shift_reg[pscl_pkg::SHIFT_W-1];
      pscl_pkg::DIAG_GATE:  diag_next = (gate_reg == GATE_ON);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_reg <= 1'b0;
    end else begin
      diag_reg <= diag_next;
    end
  end

  // ---------------------------------------------------------------------
  // apb slave: one wait-free access phase, answer registered in setup
  // ---------------------------------------------------------------------
  pscl_pkg::pscl_status_t status_w;
  logic [pscl_pkg::DATA_W-1:0] prdata_reg;
  logic [pscl_pkg::DATA_W-1:0] rd_word;
  logic                        pready_reg;
  logic                        pslverr_reg;
  logic                        ctrl_hold_next;
  wire                         setup_phase;
  wire                         access_done;
  wire                         hit_config;
  wire                         hit_shift;
  wire                         hit_status;
  wire                         hit_ctrl;
  wire                         hit_fbcnt;
  wire                         hit_any;
  wire                         ctrl_wr;

  assign status_w.gate_on    = (gate_reg == GATE_ON);
  assign status_w.out_enable = out_enable_in;
  assign status_w.ref_sel    = ref_source_select;
  assign status_w.ser_load   = ser_load_in;
  assign status_w.par_load   = par_load_in;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;

  assign hit_config = (paddr == pscl_pkg::OFS_CONFIG);
  assign hit_shift  = (paddr == pscl_pkg::OFS_SHIFT);
  assign hit_status = (paddr == pscl_pkg::OFS_STATUS);
  assign hit_ctrl   = (paddr == pscl_pkg::OFS_CTRL);
  assign hit_fbcnt  = (paddr == pscl_pkg::OFS_FBCNT);
  assign hit_any    = hit_config | hit_shift | hit_status | hit_ctrl | hit_fbcnt;

  // writes to read-only words are silently dropped, unmapped ones flag error
  assign ctrl_wr        = access_done & pwrite & hit_ctrl;
  assign ctrl_hold_next = ctrl_wr ? pwdata[pscl_pkg::CTRL_HOLD_BIT] : ctrl_hold_reg;

  always_comb begin
    rd_word = '0;
    if (hit_config) begin
      rd_word = pscl_pkg::DATA_W'(cfg_reg);
    end else if (hit_shift) begin
      rd_word = pscl_pkg::DATA_W'(shift_reg);
    end else if (hit_status) begin
      rd_word = pscl_pkg::DATA_W'(status_w);
    end else if (hit_ctrl) begin
      rd_word[pscl_pkg::CTRL_HOLD_BIT] = ctrl_hold_reg;
    end else if (hit_fbcnt) begin
      rd_word = pscl_pkg::DATA_W'(fb_total_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg    <= '0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      ctrl_hold_reg <= pscl_pkg::CTRL_HOLD_RST;
    end else begin
      prdata_reg    <= (setup_phase && !pwrite) ? rd_word : prdata_reg;
      pready_reg    <= setup_phase;
      pslverr_reg   <= setup_phase & ~hit_any;
      ctrl_hold_reg <= ctrl_hold_next;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign ref_clk_out = ref_clk_reg;
  assign synth_out   = synth_reg;
  assign diag_out    = diag_reg;
  assign loop_fb_out = fb_pulse_reg;

endmodule : pscl_top

// [test_pscl_top.sv]
// self-checking bench for the synthesizer configuration logic
`timescale 1ns/1ps
module test_pscl_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        ser_clk_in, ser_data_in, ser_load_in, par_load_in, rerr;
  logic        vph = 1'b0;
  logic        vco_in = 1'b0;
  logic [8:0]  loop_div_in;
  logic [1:0]  out_div_in;
  logic        out_enable_in, ref_source_select, external_reference_in, crystal_pins;
  logic        ref_clk_out, synth_out, diag_out, loop_fb_out;
  int          mismatches, n_checks;

  pscl_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ser_clk_in(ser_clk_in), .ser_data_in(ser_data_in),
    .ser_load_in(ser_load_in), .par_load_in(par_load_in), .loop_div_in(loop_div_in),
    .out_div_in(out_div_in), .out_enable_in(out_enable_in),
    .ref_source_select(ref_source_select), .external_reference_in(external_reference_in),
    .crystal_pins(crystal_pins), .vco_in(vco_in), .ref_clk_out(ref_clk_out),
    .synth_out(synth_out), .diag_out(diag_out), .loop_fb_out(loop_fb_out));
  pscl_host_model i_host (.pclk(pclk), .ser_clk_in(ser_clk_in),
    .ser_data_in(ser_data_in), .ser_load_in(ser_load_in));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // vco period of four pclk cycles
  always @(posedge pclk) begin
    vph <= ~vph;
    if (vph) vco_in <= ~vco_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk({31'h0, rerr}, 32'h0);
  endtask : rd
  // edges between two rises of the synthesized output
  task automatic chk_period(input int e);
    int t0;
    int p;
    logic pv;
    t0 = -1;
    p = 0;
    pv = 1'b1;
    for (int n = 0; n < 300 && p == 0; n++) begin
      @(posedge pclk);
      if (pv === 1'b0 && synth_out === 1'b1) begin
        if (t0 >= 0) p = n - t0;
        t0 = n;
      end
      pv = synth_out;
    end
    if (p == 0) begin
      mismatches++;
      end_sim();
    end
    chk(p, e);
  endtask : chk_period

  task automatic t_reset;
    rd(pscl_pkg::OFS_CONFIG, 32'h7ff);
    rd(pscl_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, pscl_pkg::OFS_CONFIG, 32'h0);
    rd(pscl_pkg::OFS_CONFIG, 32'h7ff);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 8'h06, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, pscl_pkg::OFS_STATUS, 32'h0);
    chk(rdat & 32'hf, 32'hd);
    $display("reset test done");
  endtask : t_reset
  task automatic t_par;
    @(posedge pclk);
    loop_div_in <= 9'h1a5;
    out_div_in  <= 2'h1;
    par_load_in <= 1'b0;
    repeat (3) @(posedge pclk);
    par_load_in <= 1'b1;
    @(posedge pclk);
    loop_div_in <= 9'h05a; // pins move after the latch closed
    out_div_in  <= 2'h2;
    rd(pscl_pkg::OFS_CONFIG, 32'h3a5);
    $display("parallel test done");
  endtask : t_par
  task automatic t_sweep;
    int         mult[4] = '{2, 4, 8, 1};
    logic [1:0] dexp[8] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h1};
    logic [13:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {3'(i), 2'(i), 9'h007};
      i_host.send(w, i % 2 + 1);
      rd(pscl_pkg::OFS_SHIFT, {18'h0, w});
      rd(pscl_pkg::OFS_CONFIG, {18'h0, w});
      repeat (80) @(posedge pclk);
      if (dexp[i] != 2'h2) chk(diag_out, dexp[i][0]);
      chk_period(4 * mult[i % 4]);
    end
    $display("serial sweep done");
  endtask : t_sweep
  task automatic t_gate;
    @(posedge pclk);
    out_enable_in <= 1'b0;
    repeat (60) @(posedge pclk);
    chk(synth_out, 1'b0);
    apb(1'b0, pscl_pkg::OFS_STATUS, 32'h0);
    chk(rdat[4:3], 2'h0);
    out_enable_in <= 1'b1;
    chk_period(4);
    apb(1'b1, pscl_pkg::OFS_CTRL, 32'h1);
    rd(pscl_pkg::OFS_CTRL, 32'h1);
    repeat (60) @(posedge pclk);
    chk(synth_out, 1'b0);
    apb(1'b1, pscl_pkg::OFS_CTRL, 32'h0);
    chk_period(4);
    $display("gate test done");
  endtask : t_gate
  task automatic t_ref;
    @(posedge pclk);
    crystal_pins          <= 1'b0;
    external_reference_in <= 1'b1;
    ref_source_select     <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(ref_clk_out, 1'b1);
    ref_source_select <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(ref_clk_out, 1'b0);
    $display("reference test done");
  endtask : t_ref
  // feedback pulse spacing and wrap count, loop value 7 left by the sweep
  task automatic t_fb;
    logic [31:0] c0;
    int          t0;
    int          p;
    t0 = -1;
    p  = 0;
    for (int n = 0; n < 200 && p == 0; n++) begin
      @(posedge pclk);
      if (loop_fb_out === 1'b1) begin
        if (t0 >= 0) p = n - t0;
        t0 = n;
      end
    end
    chk(p, 4 * (9'h007 + 1));
    apb(1'b0, pscl_pkg::OFS_FBCNT, 32'h0);
    c0 = rdat;
    // setup edges of the two reads lie 64 cycles apart: two wraps
    repeat (61) @(posedge pclk);
    apb(1'b0, pscl_pkg::OFS_FBCNT, 32'h0);
    chk(rdat - c0, 32'h2);
    chk({31'h0, rerr}, 32'h0);
    $display("feedback test done");
  endtask : t_fb

  initial begin
    mismatches = 0;
    n_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {par_load_in, loop_div_in, out_div_in, out_enable_in, ref_source_select} = '1;
    external_reference_in = 1'b0;
    crystal_pins = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_par();
    t_sweep();
    t_gate();
    t_ref();
    t_fb();
    end_sim();
  end
endmodule : test_pscl_top
